/* File: rxcfg_pkg.sv */
// Purpose: Shared constants for the receive chain configuration registers.
// Assumes: Serial frames of 8 address bits then 16 data bits, MSB first.
// Notes: Resistor maps for the termination presets are plain defaults.
package rxcfg_pkg;

	// Register addresses on the serial configuration port.
	localparam logic [7:0] FILT_GAIN_CFG_ADDR = 8'h33;
	localparam logic [7:0] INAMP_TERM_CFG_ADDR = 8'h34;

	// Values after reset and masks of the bits that hold a field.
	localparam logic [15:0] CFG_RESET_VAL = 16'h0000;
	localparam logic [15:0] FILT_GAIN_CFG_MASK = 16'h20fe;
	localparam logic [15:0] INAMP_TERM_CFG_MASK = 16'hf7ff;

	// Serial frame layout.
	localparam int FRAME_BITS = 24;
	localparam int ADDR_BITS = 8;
	localparam logic [4:0] LAST_BIT_IDX = 5'h17;
	localparam logic [4:0] ADDR_DONE_IDX = 5'h08;

	// Field positions in the filter and gain stage register.
	localparam int CUTOFF_LSB = 1;
	localparam int GS_OFFSET_OFF_BIT = 4;
	localparam int GS_CLAMP_LSB = 5;
	localparam int GS_GAIN_BIT = 13;

	// Field positions in the input amplifier and termination register.
	localparam int TERM_MAP_LSB = 0;
	localparam int TERM_INDIV_EN_BIT = 5;
	localparam int TERM_PRESET_LSB = 6;
	localparam int TERM_ACTIVE_EN_BIT = 8;
	localparam int IN_CLAMP_LSB = 9;
	localparam int IA_OFFSET_OFF_BIT = 12;
	localparam int IA_GAIN_LSB = 13;
	localparam int PER_CH_CTRL_BIT = 15;

	// Cutoff codes.
	localparam logic [2:0] CUTOFF_15M = 3'h0;
	localparam logic [2:0] CUTOFF_20M = 3'h2;
	localparam logic [2:0] CUTOFF_30M = 3'h3;
	localparam logic [2:0] CUTOFF_10M = 3'h4;

	// Power mode codes.
	localparam logic [1:0] PMODE_LOW_POWER = 2'h0;
	localparam logic [1:0] PMODE_LOW_NOISE = 2'h1;
	localparam logic [1:0] PMODE_MED_POWER = 2'h2;

	// Input amplifier gain codes.
	localparam logic [1:0] IA_GAIN_18DB = 2'h0;
	localparam logic [1:0] IA_GAIN_24DB = 2'h1;
	localparam logic [1:0] IA_GAIN_12DB = 2'h2;

	// Termination preset codes.
	localparam logic [1:0] PRESET_50 = 2'h0;
	localparam logic [1:0] PRESET_100 = 2'h1;
	localparam logic [1:0] PRESET_200 = 2'h2;
	localparam logic [1:0] PRESET_400 = 2'h3;

	// Internal resistor maps derived from each preset.
	localparam logic [4:0] PRESET_MAP_50 = 5'h01;
	localparam logic [4:0] PRESET_MAP_100 = 5'h02;
	localparam logic [4:0] PRESET_MAP_200 = 5'h04;
	localparam logic [4:0] PRESET_MAP_400 = 5'h08;
	localparam logic [4:0] PRESET_MAP_HIGH_Z = 5'h00;

	// System clock edges from write strobe to decoded outputs.
	localparam int APPLY_LATENCY_CYC = 2;

endpackage

/* File: serial_cfg_port.sv */
// Purpose: Serial configuration port: shifts in write frames, shifts out readback.
// Assumes: Port pins are synchronous to the system clock and SCLK is much slower.
// Notes: Writes are ignored while readout is enabled; bits past the 24th are dropped.
module serial_cfg_port
	import rxcfg_pkg::*;
(
	input wire logic clk_i, // System clock.
	input wire logic rst_n_i, // Asynchronous reset, active low.
	input wire logic sclk_i, // Serial clock level.
	input wire logic sen_n_i, // Frame enable, active low.
	input wire logic sdata_i, // Serial data in.
	input wire logic readout_en_i, // High turns frames into reads.
	input wire logic [15:0] rd_data_i, // Read value for rd_addr_o.
	output logic [7:0] rd_addr_o, // Address captured for readback.
	output logic wr_stb_o, // One-cycle write strobe.
	output logic [7:0] wr_addr_o, // Write address.
	output logic [15:0] wr_data_o, // Write data.
	output logic sdout_o // Serial data out.
);

	logic sclk_q;
	logic [4:0] bit_cnt_q;
	logic [22:0] shift_q;
	logic [15:0] out_sh_q;
	logic rise;
	logic fall;
	logic [23:0] word;

	// Edge detection on the sampled serial clock, only inside a frame.
	assign rise = sclk_i & ~sclk_q & ~sen_n_i;
	assign fall = ~sclk_i & sclk_q & ~sen_n_i;
	assign word = {shift_q, sdata_i};

	// Previous serial clock level.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk_i;
		end
	end

	// Bit counter and input shifter; a frame end restarts the count.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_cnt_q <= 5'h00;
			shift_q <= 23'h0;
		end else if (sen_n_i) begin
			bit_cnt_q <= 5'h00;
		end else if (rise && bit_cnt_q <= LAST_BIT_IDX) begin
			bit_cnt_q <= bit_cnt_q + 5'h01;
			shift_q <= word[22:0];
		end
	end

	// Write strobe on the 24th bit; the strobe lasts one system cycle.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_stb_o <= 1'b0;
			wr_addr_o <= 8'h00;
			wr_data_o <= 16'h0000;
		end else begin
			wr_stb_o <= rise && bit_cnt_q == LAST_BIT_IDX && !readout_en_i;
			if (rise && bit_cnt_q == LAST_BIT_IDX) begin
				wr_addr_o <= word[23:16];
				wr_data_o <= word[15:0];
			end
		end
	end

	// Address for readback, caught on the eighth bit.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_addr_o <= 8'h00;
		end else if (rise && bit_cnt_q == ADDR_DONE_IDX - 5'h01) begin
			rd_addr_o <= word[7:0];
		end
	end

	// Readback shifter: loads on the falling edge after the address, then shifts.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_sh_q <= 16'h0000;
			sdout_o <= 1'b0;
		end else if (!readout_en_i || sen_n_i) begin
			out_sh_q <= 16'h0000;
			sdout_o <= 1'b0;
		end else if (fall && bit_cnt_q == ADDR_DONE_IDX) begin
			out_sh_q <= {rd_data_i[14:0], 1'b0};
			sdout_o <= rd_data_i[15];
		end else if (fall && bit_cnt_q > ADDR_DONE_IDX) begin
			out_sh_q <= {out_sh_q[14:0], 1'b0};
			sdout_o <= out_sh_q[15];
		end
	end

endmodule

/* File: chain_decode.sv */
// Purpose: Turns the two configuration words into per-block control selects.
// Assumes: Power mode comes from outside this block.
// Notes: Purely combinational; the top module registers every result.
module chain_decode
	import rxcfg_pkg::*;
(
	input wire logic [15:0] fg_i, // Filter and gain stage word.
	input wire logic [15:0] it_i, // Input amplifier and termination word.
	input wire logic [1:0] pmode_i, // Power mode code.
	output logic [3:0] cutoff_o, // One-hot 10/15/20/30 MHz.
	output logic clamp_en_o, // Gain stage clamp on.
	output logic clamp_0dbfs_o, // Clamp at 0 dBFS, else -2 dBFS.
	output logic [2:0] pmode_sel_o, // One-hot low power/low noise/medium.
	output logic [3:0] preset_o, // One-hot 50/100/200/400 ohm.
	output logic high_z_o, // High impedance input.
	output logic [4:0] res_map_o, // Resistor map in use.
	output logic [3:0] in_clamp_o, // One-hot auto/1.5/1.15/0.6 Vpp.
	output logic [2:0] ia_gain_o // One-hot 18/24/12 dB.
);

	logic [2:0] cut;
	logic [2:0] clamp;
	logic [1:0] preset;
	logic [1:0] ia_gain;

	assign cut = fg_i[CUTOFF_LSB +: 3];
	assign clamp = fg_i[GS_CLAMP_LSB +: 3];
	assign preset = it_i[TERM_PRESET_LSB +: 2];
	assign ia_gain = it_i[IA_GAIN_LSB +: 2];

	// Decodes for the filter, clamp and power mode.
	always_comb begin
		unique case (cut)
			CUTOFF_10M: cutoff_o = 4'h1;
			CUTOFF_20M: cutoff_o = 4'h4;
			CUTOFF_30M: cutoff_o = 4'h8;
			default: cutoff_o = 4'h2;
		endcase
		unique case (pmode_i)
			PMODE_LOW_NOISE: pmode_sel_o = 3'h2;
			PMODE_MED_POWER: pmode_sel_o = 3'h4;
			PMODE_LOW_POWER: pmode_sel_o = 3'h1;
			default: pmode_sel_o = 3'h0;
		endcase
		// RL5 mode selects meaning
		if (pmode_i == PMODE_LOW_NOISE) begin
			// RL4 low noise clamp
			clamp_en_o = ~clamp[2];
		end else if (pmode_i == PMODE_LOW_POWER || pmode_i == PMODE_MED_POWER) begin
			// RL3 low/medium clamp
			clamp_en_o = clamp[2];
		end else begin
			clamp_en_o = 1'b0;
		end
		clamp_0dbfs_o = clamp_en_o & clamp[1];
	end

	// Termination and input amplifier decodes.
	always_comb begin
		in_clamp_o = 4'h1 << it_i[IN_CLAMP_LSB +: 2];
		unique case (ia_gain)
			IA_GAIN_24DB: ia_gain_o = 3'h2;
			IA_GAIN_12DB: ia_gain_o = 3'h4;
			default: ia_gain_o = 3'h1;
		endcase
		preset_o = 4'h1 << preset;
		high_z_o = 1'b0;
		unique case (preset)
			PRESET_50: res_map_o = PRESET_MAP_50;
			PRESET_100: res_map_o = PRESET_MAP_100;
			PRESET_200: res_map_o = PRESET_MAP_200;
			PRESET_400: res_map_o = PRESET_MAP_400;
		endcase
		// RL11 no 50 ohm at 12 dB
		if (ia_gain == IA_GAIN_12DB && preset == PRESET_50 && !it_i[TERM_INDIV_EN_BIT]) begin
			high_z_o = 1'b1;
			res_map_o = PRESET_MAP_HIGH_Z;
			preset_o = 4'h0;
		end
		// RL8 individual map wins
		if (it_i[TERM_INDIV_EN_BIT]) begin
			res_map_o = it_i[TERM_MAP_LSB +: 5];
		end
	end

endmodule

/* File: receive_chain_config_regs.sv */
// Purpose: Receive chain configuration registers written over the serial port.
// Assumes: All pins are synchronous to CLK_SYS_I; power mode arrives as an input.
// Notes: Decoded controls follow a write by two system clock edges.
//
// Overview of operation
// RL1: Cutoff code selects 15/20/30/10 MHz.
// RL2: Gain stage offset loop off bit.
// RL3: Low/medium power clamp codes 100, 110.
// RL4: Low noise clamp codes 000, 010.
// RL5: Power mode sets clamp code meaning.
// RL6: Host should use clamp 000 in low noise.
// RL7: Individual resistor field needs enable set.
// RL8: Enable bit hands map to individual field.
// RL9: Preset selects 50/100/200/400 ohm.
// RL10: Preset derives resistor map automatically.
// RL11: At 12 dB, preset 00 is high-Z.
// RL12: Active termination enable bit.
// RL13: Input clamp auto/1.5/1.15/0.6 Vpp.
// RL14: Input amp offset loop off bit.
// RL15: Input amp gain 18/24/12 dB, 11 reserved.
// RL16: Per-channel input amp control enable.
// RL17: Power mode low/low noise/medium, 11 reserved.
// RL18: Write takes effect within few cycles.
// RL19: Reset zero, undefined bits read zero.
module receive_chain_config_regs
	import rxcfg_pkg::*;
(
	input wire logic CLK_SYS_I, // 25 MHz system clock.
	input wire logic RST_N_I, // Asynchronous reset, active low.
	input wire logic SCLK_I, // Serial clock.
	input wire logic SEN_N_I, // Serial frame enable, active low.
	input wire logic SDATA_I, // Serial data in.
	input wire logic READOUT_EN_I, // High makes frames read back.
	input wire logic [1:0] POWER_MODE_I, // Power mode code.
	output logic SDOUT_O, // Serial readback data.
	output logic [15:0] FILT_GAIN_CFG_O, // Filter and gain stage word.
	output logic [15:0] INAMP_TERM_CFG_O, // Input amp and termination word.
	output logic [3:0] CUTOFF_SEL_O, // One-hot 10/15/20/30 MHz.
	output logic GAIN_STAGE_OFFSET_LOOP_OFF_O, // Gain stage integrator off.
	output logic GAIN_STAGE_30DB_O, // Gain stage at 30 dB, else 24 dB.
	output logic GAIN_STAGE_CLAMP_EN_O, // Gain stage clamp on.
	output logic GAIN_STAGE_CLAMP_0DBFS_O, // Clamp at 0 dBFS, else -2 dBFS.
	output logic [2:0] POWER_MODE_SEL_O, // One-hot low power/low noise/medium.
	output logic TERM_ACTIVE_EN_O, // Active termination on.
	output logic TERM_INDIV_EN_O, // Individual resistor control on.
	output logic [3:0] TERM_PRESET_SEL_O, // One-hot 50/100/200/400 ohm.
	output logic TERM_HIGH_Z_O, // High impedance input.
	output logic [4:0] TERM_RES_MAP_O, // Resistor map in use.
	output logic [3:0] INPUT_CLAMP_SEL_O, // One-hot auto/1.5/1.15/0.6 Vpp.
	output logic INPUT_AMP_OFFSET_LOOP_OFF_O, // Input amp integrator off.
	output logic [2:0] INPUT_AMP_GAIN_SEL_O, // One-hot 18/24/12 dB.
	output logic PER_CH_INPUT_AMP_EN_O // Per-channel input amp settings.
);

	logic wr_stb;
	logic [7:0] wr_addr;
	logic [15:0] wr_data;
	logic [7:0] rd_addr;
	logic [3:0] cutoff_d;
	logic clamp_en_d;
	logic clamp_0dbfs_d;
	logic [2:0] pmode_sel_d;
	logic [3:0] preset_d;
	logic high_z_d;
	logic [4:0] res_map_d;
	logic [3:0] in_clamp_d;
	logic [2:0] ia_gain_d;

	// Readback value: unmapped addresses and undefined bits read as zero.
	function automatic logic [15:0] read_value(input logic [7:0] addr, input logic [15:0] fg,
			input logic [15:0] it);
		if (addr == FILT_GAIN_CFG_ADDR) begin
			return fg & FILT_GAIN_CFG_MASK;
		end else if (addr == INAMP_TERM_CFG_ADDR) begin
			return it & INAMP_TERM_CFG_MASK;
		end
		return 16'h0000;
	endfunction

	serial_cfg_port u_port (
		.clk_i(CLK_SYS_I),
		.rst_n_i(RST_N_I),
		.sclk_i(SCLK_I),
		.sen_n_i(SEN_N_I),
		.sdata_i(SDATA_I),
		.readout_en_i(READOUT_EN_I),
		.rd_data_i(read_value(rd_addr, FILT_GAIN_CFG_O, INAMP_TERM_CFG_O)),
		.rd_addr_o(rd_addr),
		.wr_stb_o(wr_stb),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.sdout_o(SDOUT_O)
	);

	chain_decode u_dec (
		.fg_i(FILT_GAIN_CFG_O),
		.it_i(INAMP_TERM_CFG_O),
		.pmode_i(POWER_MODE_I),
		.cutoff_o(cutoff_d),
		.clamp_en_o(clamp_en_d),
		.clamp_0dbfs_o(clamp_0dbfs_d),
		.pmode_sel_o(pmode_sel_d),
		.preset_o(preset_d),
		.high_z_o(high_z_d),
		.res_map_o(res_map_d),
		.in_clamp_o(in_clamp_d),
		.ia_gain_o(ia_gain_d)
	);

	// Register writes; masking keeps undefined bits at zero forever.
	// RL19 reset and masking
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			FILT_GAIN_CFG_O <= CFG_RESET_VAL;
			INAMP_TERM_CFG_O <= CFG_RESET_VAL;
		end else if (wr_stb) begin
			if (wr_addr == FILT_GAIN_CFG_ADDR) begin
				FILT_GAIN_CFG_O <= wr_data & FILT_GAIN_CFG_MASK;
			end
			if (wr_addr == INAMP_TERM_CFG_ADDR) begin
				INAMP_TERM_CFG_O <= wr_data & INAMP_TERM_CFG_MASK;
			end
		end
	end

	// Decoded controls are registered so the analog side sees clean levels.
	// RL18 apply after write
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			CUTOFF_SEL_O <= 4'h2;
			GAIN_STAGE_CLAMP_EN_O <= 1'b0;
			GAIN_STAGE_CLAMP_0DBFS_O <= 1'b0;
			POWER_MODE_SEL_O <= 3'h1;
			TERM_PRESET_SEL_O <= 4'h1;
			TERM_HIGH_Z_O <= 1'b0;
			TERM_RES_MAP_O <= PRESET_MAP_50;
			INPUT_CLAMP_SEL_O <= 4'h1;
			INPUT_AMP_GAIN_SEL_O <= 3'h1;
		end else begin
			// RL1 cutoff decode
			CUTOFF_SEL_O <= cutoff_d;
			GAIN_STAGE_CLAMP_EN_O <= clamp_en_d;
			GAIN_STAGE_CLAMP_0DBFS_O <= clamp_0dbfs_d;
			// RL17 power mode decode
			POWER_MODE_SEL_O <= pmode_sel_d;
			// RL9 preset select
			TERM_PRESET_SEL_O <= preset_d;
			TERM_HIGH_Z_O <= high_z_d;
			// RL10 derived resistor map
			TERM_RES_MAP_O <= res_map_d;
			// RL13 input clamp decode
			INPUT_CLAMP_SEL_O <= in_clamp_d;
			// RL15 input gain decode
			INPUT_AMP_GAIN_SEL_O <= ia_gain_d;
		end
	end

	// Single-bit controls copied straight from their fields.
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			GAIN_STAGE_OFFSET_LOOP_OFF_O <= 1'b0;
			GAIN_STAGE_30DB_O <= 1'b0;
			TERM_ACTIVE_EN_O <= 1'b0;
			TERM_INDIV_EN_O <= 1'b0;
			INPUT_AMP_OFFSET_LOOP_OFF_O <= 1'b0;
			PER_CH_INPUT_AMP_EN_O <= 1'b0;
		end else begin
			// RL2 gain stage integrator
			GAIN_STAGE_OFFSET_LOOP_OFF_O <= FILT_GAIN_CFG_O[GS_OFFSET_OFF_BIT];
			GAIN_STAGE_30DB_O <= FILT_GAIN_CFG_O[GS_GAIN_BIT];
			// RL12 active termination
			TERM_ACTIVE_EN_O <= INAMP_TERM_CFG_O[TERM_ACTIVE_EN_BIT];
			// RL7 individual enable
			TERM_INDIV_EN_O <= INAMP_TERM_CFG_O[TERM_INDIV_EN_BIT];
			// RL14 input integrator
			INPUT_AMP_OFFSET_LOOP_OFF_O <= INAMP_TERM_CFG_O[IA_OFFSET_OFF_BIT];
			// RL16 per-channel control
			PER_CH_INPUT_AMP_EN_O <= INAMP_TERM_CFG_O[PER_CH_CTRL_BIT];
		end
	end

	// Checks of the decoded controls against the stored words.
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!RST_N_I);

	sequence s_fg_write;
		wr_stb && wr_addr == FILT_GAIN_CFG_ADDR;
	endsequence

	property p_write_applies;
		s_fg_write |=> FILT_GAIN_CFG_O == ($past(wr_data) & FILT_GAIN_CFG_MASK)
			##1 GAIN_STAGE_30DB_O == $past(FILT_GAIN_CFG_O[GS_GAIN_BIT]);
	endproperty
	a_write_applies: assert property (p_write_applies) else $error("Write not applied in time."); // RL18

	property p_cutoff;
		FILT_GAIN_CFG_O[CUTOFF_LSB +: 3] == CUTOFF_10M |=> CUTOFF_SEL_O == 4'h1;
	endproperty
	a_cutoff: assert property (p_cutoff) else $error("10 MHz cutoff not selected."); // RL1

	property p_gs_loop;
		FILT_GAIN_CFG_O[GS_OFFSET_OFF_BIT] |=> GAIN_STAGE_OFFSET_LOOP_OFF_O;
	endproperty
	a_gs_loop: assert property (p_gs_loop) else $error("Gain stage loop not off."); // RL2

	property p_clamp_lp;
		POWER_MODE_I == PMODE_LOW_POWER && FILT_GAIN_CFG_O[GS_CLAMP_LSB +: 3] == 3'h6
			|=> GAIN_STAGE_CLAMP_EN_O && GAIN_STAGE_CLAMP_0DBFS_O;
	endproperty
	a_clamp_lp: assert property (p_clamp_lp) else $error("Low power 0 dBFS clamp wrong."); // RL3

	property p_clamp_ln;
		POWER_MODE_I == PMODE_LOW_NOISE && FILT_GAIN_CFG_O[GS_CLAMP_LSB + 2]
			|=> !GAIN_STAGE_CLAMP_EN_O;
	endproperty
	a_clamp_ln: assert property (p_clamp_ln) else $error("Low noise clamp not disabled."); // RL4

	property p_clamp_mode;
		FILT_GAIN_CFG_O[GS_CLAMP_LSB +: 3] == 3'h0
			|=> GAIN_STAGE_CLAMP_EN_O == POWER_MODE_SEL_O[1];
	endproperty
	a_clamp_mode: assert property (p_clamp_mode) else $error("Clamp ignores power mode."); // RL5

	property p_indiv_map;
		INAMP_TERM_CFG_O[TERM_INDIV_EN_BIT]
			|=> TERM_RES_MAP_O == $past(INAMP_TERM_CFG_O[TERM_MAP_LSB +: 5]);
	endproperty
	a_indiv_map: assert property (p_indiv_map) else $error("Individual map not used."); // RL8

	property p_preset_map;
		!INAMP_TERM_CFG_O[TERM_INDIV_EN_BIT] && INAMP_TERM_CFG_O[TERM_PRESET_LSB +: 2] == PRESET_400
			|=> TERM_RES_MAP_O == PRESET_MAP_400 && TERM_PRESET_SEL_O == 4'h8;
	endproperty
	a_preset_map: assert property (p_preset_map) else $error("Preset map not derived."); // RL10

	property p_high_z;
		!INAMP_TERM_CFG_O[TERM_INDIV_EN_BIT] && INAMP_TERM_CFG_O[IA_GAIN_LSB +: 2] == IA_GAIN_12DB
			&& INAMP_TERM_CFG_O[TERM_PRESET_LSB +: 2] == PRESET_50 |=> TERM_HIGH_Z_O;
	endproperty
	a_high_z: assert property (p_high_z) else $error("12 dB preset 00 not high-Z."); // RL11

	property p_reserved_zero;
		(FILT_GAIN_CFG_O & ~FILT_GAIN_CFG_MASK) == 16'h0000
			&& (INAMP_TERM_CFG_O & ~INAMP_TERM_CFG_MASK) == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("Undefined bit set."); // RL19

	// Copied bits are compared both ways, so a stuck output cannot slip through.
	property p_indiv_en;
		TERM_INDIV_EN_O == $past(INAMP_TERM_CFG_O[TERM_INDIV_EN_BIT]);
	endproperty
	a_indiv_en: assert property (p_indiv_en) else $error("Indiv enable not copied."); // RL7

	property p_active_term;
		TERM_ACTIVE_EN_O == $past(INAMP_TERM_CFG_O[TERM_ACTIVE_EN_BIT]);
	endproperty
	a_active_term: assert property (p_active_term) else $error("Active term not copied."); // RL12

	property p_ia_loop;
		INPUT_AMP_OFFSET_LOOP_OFF_O == $past(INAMP_TERM_CFG_O[IA_OFFSET_OFF_BIT]);
	endproperty
	a_ia_loop: assert property (p_ia_loop) else $error("Input loop bit not copied."); // RL14

	property p_per_ch;
		PER_CH_INPUT_AMP_EN_O == $past(INAMP_TERM_CFG_O[PER_CH_CTRL_BIT]);
	endproperty
	a_per_ch: assert property (p_per_ch) else $error("Per-channel bit not copied."); // RL16

	// Decodes that the checks above leave open.
	property p_preset_sel;
		INAMP_TERM_CFG_O[TERM_PRESET_LSB +: 2] == PRESET_100
			|=> TERM_PRESET_SEL_O == 4'h2;
	endproperty
	a_preset_sel: assert property (p_preset_sel) else $error("100 ohm preset not set."); // RL9

	property p_in_clamp;
		INAMP_TERM_CFG_O[IN_CLAMP_LSB +: 2] == 2'h3
			|=> INPUT_CLAMP_SEL_O == 4'h8;
	endproperty
	a_in_clamp: assert property (p_in_clamp) else $error("0.6 Vpp clamp not set."); // RL13

	property p_ia_gain;
		INAMP_TERM_CFG_O[IA_GAIN_LSB +: 2] == IA_GAIN_24DB
			|=> INPUT_AMP_GAIN_SEL_O == 3'h2;
	endproperty
	a_ia_gain: assert property (p_ia_gain) else $error("24 dB gain not set."); // RL15

	property p_pmode_sel;
		POWER_MODE_I == PMODE_MED_POWER
			|=> POWER_MODE_SEL_O == 3'h4;
	endproperty
	a_pmode_sel: assert property (p_pmode_sel) else $error("Medium power not set."); // RL17

	property p_clamp_mp;
		POWER_MODE_I == PMODE_MED_POWER && FILT_GAIN_CFG_O[GS_CLAMP_LSB +: 3] == 3'h4
			|=> GAIN_STAGE_CLAMP_EN_O && !GAIN_STAGE_CLAMP_0DBFS_O;
	endproperty
	a_clamp_mp: assert property (p_clamp_mp) else $error("Medium power clamp wrong."); // RL3

	property p_clamp_ln_on;
		POWER_MODE_I == PMODE_LOW_NOISE && FILT_GAIN_CFG_O[GS_CLAMP_LSB +: 3] == 3'h2
			|=> GAIN_STAGE_CLAMP_EN_O && GAIN_STAGE_CLAMP_0DBFS_O;
	endproperty
	a_clamp_ln_on: assert property (p_clamp_ln_on) else $error("Low noise 0 dBFS wrong."); // RL4

endmodule

/* File: host_model.sv */
// Purpose: Host controller model that writes and reads the serial configuration port.
// Assumes: Each serial clock phase lasts two system cycles; frames are 8 address, 16 data bits.
// Notes: Between frames the serial clock stays low and the data line shows the inverted last bit.
module host_model (
	input wire logic clk_i, // System clock.
	input wire logic sdout_i, // Readback data from the device.
	output logic sclk_o, // Serial clock.
	output logic sen_n_o, // Frame enable, active low.
	output logic sdata_o, // Serial data out.
	output logic readout_en_o // High makes the frame a read.
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle levels before the first frame.
	initial begin
		sclk_o = 1'b0;
		sen_n_o = 1'b1;
		sdata_o = 1'b0;
		readout_en_o = 1'b0;
	end

	// One frame; a short count of bits aborts it so the device must drop it.
	task automatic xfer(input logic rd, input logic [7:0] addr, input logic [15:0] data,
		input int nbits, output logic [15:0] rdata);
		logic [23:0] frame;
		frame = {addr, data};
		rdata = 16'h0000;
		@(posedge clk_i);
		readout_en_o <= rd;
		sen_n_o <= 1'b0;
		for (int i = 0; i < nbits; i++) begin
			sdata_o <= frame[23 - i];
			sclk_o <= 1'b0;
			repeat (2) @(posedge clk_i);
			sclk_o <= 1'b1;
			repeat (2) @(posedge clk_i);
			// Readback is taken at the end of the high phase, long after it settled.
			if (i >= 8) rdata[23 - i] = sdout_i;
		end
		sclk_o <= 1'b0;
		sen_n_o <= 1'b1;
		readout_en_o <= 1'b0;
		sdata_o <= ~frame[24 - nbits];
	endtask
endmodule

/* File: test_receive_chain_config_regs.sv */
// Purpose: Self-checking bench for the receive chain configuration registers.
// Assumes: Host model drives the serial port; power mode never takes the reserved code.
// Notes: Expected words and decodes are rebuilt here from the field layout.
`define CHECK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
	$display("Error %s expected %h seen %h", nm, ex, got); end end
module test_receive_chain_config_regs
	import rxcfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, rst_n, sclk, sen_n, sdata, rd_en, sdout;
	logic [1:0] pm;
	logic [15:0] fg_w, it_w;
	logic [3:0] cutoff, preset_sel, in_clamp;
	logic gs_off, gs_30, clamp_en, clamp_0, term_act, term_ind, high_z, ia_off, per_ch;
	logic [2:0] pm_sel, ia_gain;
	logic [4:0] res_map;
	int err_total = 0;
	int n_compared = 0;
	// Termination corners: 12 dB with preset 00, individual override, 200 ohm, plain 50 ohm.
	localparam logic [15:0] CORNER_IT [4] = '{16'h4000, 16'h4035, 16'h4080, 16'h0000};

	receive_chain_config_regs uut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .SCLK_I(sclk),
		.SEN_N_I(sen_n), .SDATA_I(sdata), .READOUT_EN_I(rd_en), .POWER_MODE_I(pm),
		.SDOUT_O(sdout), .FILT_GAIN_CFG_O(fg_w), .INAMP_TERM_CFG_O(it_w),
		.CUTOFF_SEL_O(cutoff), .GAIN_STAGE_OFFSET_LOOP_OFF_O(gs_off),
		.GAIN_STAGE_30DB_O(gs_30), .GAIN_STAGE_CLAMP_EN_O(clamp_en),
		.GAIN_STAGE_CLAMP_0DBFS_O(clamp_0), .POWER_MODE_SEL_O(pm_sel),
		.TERM_ACTIVE_EN_O(term_act), .TERM_INDIV_EN_O(term_ind),
		.TERM_PRESET_SEL_O(preset_sel), .TERM_HIGH_Z_O(high_z), .TERM_RES_MAP_O(res_map),
		.INPUT_CLAMP_SEL_O(in_clamp), .INPUT_AMP_OFFSET_LOOP_OFF_O(ia_off),
		.INPUT_AMP_GAIN_SEL_O(ia_gain), .PER_CH_INPUT_AMP_EN_O(per_ch));

	host_model host (.clk_i(clk), .sdout_i(sdout), .sclk_o(sclk), .sen_n_o(sen_n),
		.sdata_o(sdata), .readout_en_o(rd_en));

	// Free-running 25 MHz system clock.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
	endfunction

	// Undefined cutoff codes fall back to 15 MHz.
	function automatic logic [3:0] exp_cutoff(input logic [2:0] c);
		case (c)
			CUTOFF_10M: return 4'h1;
			CUTOFF_20M: return 4'h4;
			CUTOFF_30M: return 4'h8;
			default: return 4'h2;
		endcase
	endfunction

	// Individual control wins over the preset; high impedance maps no resistor.
	function automatic logic [4:0] exp_map(input logic [15:0] it, input logic hz);
		if (it[5]) return it[4:0];
		if (hz) return PRESET_MAP_HIGH_Z;
		case (it[7:6])
			PRESET_50: return PRESET_MAP_50;
			PRESET_100: return PRESET_MAP_100;
			PRESET_200: return PRESET_MAP_200;
			default: return PRESET_MAP_400;
		endcase
	endfunction

	task automatic check_all(input logic [15:0] fg, input logic [15:0] it, input logic [1:0] m);
		logic hz, en;
		hz = (it[14:13] == IA_GAIN_12DB) && (it[7:6] == PRESET_50) && !it[5];
		en = (m == PMODE_LOW_NOISE) ? !fg[7] : fg[7];
		`CHECK("filt_gain_word", fg & FILT_GAIN_CFG_MASK, fg_w)
		`CHECK("inamp_term_word", it & INAMP_TERM_CFG_MASK, it_w)
		`CHECK("cutoff_sel", exp_cutoff(fg[3:1]), cutoff)
		`CHECK("gs_offset_off", fg[4], gs_off)
		`CHECK("gs_gain_30db", fg[13], gs_30)
		`CHECK("clamp_en", en, clamp_en)
		`CHECK("clamp_0dbfs", en & fg[6], clamp_0)
		`CHECK("pmode_sel", 3'h1 << m, pm_sel)
		`CHECK("term_active", it[8], term_act)
		`CHECK("term_indiv", it[5], term_ind)
		`CHECK("preset_sel", hz ? 4'h0 : 4'h1 << it[7:6], preset_sel)
		`CHECK("high_z", hz, high_z)
		`CHECK("res_map", exp_map(it, hz), res_map)
		`CHECK("in_clamp", 4'h1 << it[10:9], in_clamp)
		`CHECK("ia_offset_off", it[12], ia_off)
		`CHECK("ia_gain", 3'h1 << it[14:13], ia_gain)
		`CHECK("per_ch_ctrl", it[15], per_ch)
	endtask

	task automatic complete_run();
		$display("Compared %0d values, %0d mismatches", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence: reset, swept writes with readback, refused frames, second reset.
	initial begin
		logic [15:0] rd, fg_e, it_e;
		logic [31:0] r;
		rst_n = 1'b0;
		pm = PMODE_LOW_POWER;
		r = 32'h5c93dbbe;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		check_all(16'h0000, 16'h0000, PMODE_LOW_POWER);
		host.xfer(1'b1, INAMP_TERM_CFG_ADDR, 16'h0000, 24, rd);
		`CHECK("readback_reset", 16'h0000, rd)
		$display("Test reset done");
		// Legal modes only, clamp 000 tried in low noise.
		for (int m = 0; m < 3; m++) begin
			for (int c = 0; c < 8; c++) begin
				r = lfsr_next(r);
				fg_e = (r[15:0] & 16'hff11) | 16'(c << 5) | 16'(c << 1);
				it_e = (c < 4) ? CORNER_IT[c] : r[31:16];
				if (it_e[14:13] == 2'h3) it_e[14] = 1'b0;
				pm <= 2'(m);
				host.xfer(1'b0, FILT_GAIN_CFG_ADDR, fg_e, 24, rd);
				host.xfer(1'b0, INAMP_TERM_CFG_ADDR, it_e, 24, rd);
				// Settle before relying on the new value.
				repeat (4) @(posedge clk);
				check_all(fg_e, it_e, 2'(m));
				host.xfer(1'b1, FILT_GAIN_CFG_ADDR, r[31:16], 24, rd);
				`CHECK("readback_fg", fg_e & FILT_GAIN_CFG_MASK, rd)
				host.xfer(1'b1, INAMP_TERM_CFG_ADDR, ~r[15:0], 24, rd);
				`CHECK("readback_it", it_e & INAMP_TERM_CFG_MASK, rd)
			end
		end
		$display("Test field sweep done");
		host.xfer(1'b0, FILT_GAIN_CFG_ADDR, ~fg_e, 12, rd);
		host.xfer(1'b0, 8'h35, ~it_e, 24, rd);
		repeat (4) @(posedge clk);
		check_all(fg_e, it_e, pm);
		host.xfer(1'b1, 8'h35, 16'hffff, 24, rd);
		`CHECK("readback_unmapped", 16'h0000, rd)
		$display("Test refused frames done");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		check_all(16'h0000, 16'h0000, pm);
		$display("Test second reset done");
		complete_run();
	end

	// Watchdog: the run needs about 9800 cycles.
	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		$display("Error watchdog expected finish seen hang");
		complete_run();
	end
endmodule
